// file: mcuyc_layer.sv
// foreground layer: ycbcr mcu blocks to raster rgb pixels
//
// Function
// - take decoder mcus, emit reordered raster rgb with chroma up-sampling in one pass
// - serve 4:4:4, 4:2:2 and 4:2:0 mcus only
// - of the two layers only this foreground path converts mcus
// - the mcu to rgb capability belongs to the foreground, not the background
// - subsample select 00 is 4:4:4, 01 is 4:2:2, 10 is 4:2:0
// - colour mode 1011 means the input is ycbcr mcu data
// - line offset pixels past the true width are dropped each line
// - 4:4:4 mcu is y, cb, cr blocks, 192 bytes
// - 4:2:2 mcu is two y, cb, cr blocks
// - 4:2:0 mcu is four y, cb, cr blocks, 384 bytes
`timescale 1ns/1ps
module mcuyc_layer #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [mcuyc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mcuyc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [mcuyc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [23:0] out_rgb,
    output logic [15:0] out_x,
    output logic [15:0] out_y,
    output logic busy
);
    import mcuyc_pkg::*;

    // ==========================================================
    // parameter check
    // ==========================================================
    generate
        if (FIFO_DEPTH < 2) begin : g_bad_fifo
            $error("fifo depth below two cannot buffer pixels");
        end
    endgenerate

    // ==========================================================
    // declarations
    // ==========================================================
    logic [3:0] fmt_ff;
    logic [1:0] smp_ff;
    logic [15:0] lofs_ff;
    logic [15:0] mcu_cols_ff;
    logic [15:0] mcu_rows_ff;
    logic err_ff;
    logic [31:0] pix_cnt_ff;
    logic [DATA_W-1:0] rdata_ff;
    mcuyc_state_e state_ff;
    mcuyc_state_e nxt_state;
    logic in_ready_ff;
    logic busy_ff;
    logic [1:0] smp_run_ff;
    logic [8:0] byte_cnt_ff;
    logic [3:0] pix_r_ff;
    logic [3:0] pix_c_ff;
    logic [15:0] mcu_col_ff;
    logic [15:0] mcu_row_ff;
    logic out_valid_ff;
    logic [PIX_W-1:0] out_word_ff;
    logic [7:0] mcu_mem [MCU_MAX_BYTES];

    logic wr_pfc;
    logic wr_ctrl;
    logic start_req;
    logic cfg_ok;
    logic [8:0] mcu_bytes;
    logic byte_take;
    logic last_byte;
    logic [3:0] mcu_w_m1;
    logic [3:0] mcu_h_m1;
    logic [19:0] img_x;
    logic [19:0] img_y;
    logic [19:0] true_w;
    logic skip_pix;
    logic last_pix;
    logic last_col;
    logic last_mcu;
    logic pix_step;
    logic [8:0] y_addr;
    logic [8:0] cb_addr;
    logic [8:0] cr_addr;
    logic [23:0] pix_rgb;

    mcuyc_strm_if #(.W(PIX_W)) fill_if ();
    mcuyc_strm_if #(.W(PIX_W)) drain_if ();

    // ==========================================================
    // register writes
    // ==========================================================
    assign wr_pfc = ce && reg_wr && (reg_addr == REG_PFC_OFS);
    assign wr_ctrl = ce && reg_wr && (reg_addr == REG_CTRL_OFS);
    assign start_req = wr_ctrl && reg_wdata[CTRL_START_BIT] && (state_ff == ST_IDLE);
    // only ycbcr input with a defined subsample code may start
    assign cfg_ok = (fmt_ff == FMT_YCBCR) && (smp_ff != 2'h3);

    // format, offset and geometry; writes ignored while ce is low
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fmt_ff <= FMT_RST;
            smp_ff <= SMP_RST;
            lofs_ff <= LOFS_RST;
            mcu_cols_ff <= GEOM_RST;
            mcu_rows_ff <= GEOM_RST;
        end else if (ce && reg_wr) begin
            if (reg_addr == REG_PFC_OFS) begin
                fmt_ff <= reg_wdata[FMT_MSB:FMT_LSB];
                smp_ff <= reg_wdata[SMP_MSB:SMP_LSB];
            end else if (reg_addr == REG_LOFS_OFS) begin
                lofs_ff <= reg_wdata[15:0];
            end else if (reg_addr == REG_GEOM_OFS) begin
                mcu_cols_ff <= reg_wdata[GEOM_COLS_LSB +: 16];
                mcu_rows_ff <= reg_wdata[GEOM_ROWS_LSB +: 16];
            end
        end
    end

    // sticky start error; a new refusal wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            err_ff <= 1'b0;
        end else if (ce) begin
            if (start_req && !cfg_ok) begin
                err_ff <= 1'b1;
            end else if (wr_ctrl && reg_wdata[CTRL_ERR_BIT]) begin
                err_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // register reads, data in the following cycle only
    // ==========================================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= '0;
        end else if (ce) begin
            rdata_ff <= '0;
            if (reg_rd) begin
                if (reg_addr == REG_PFC_OFS) begin
                    rdata_ff[SMP_MSB:SMP_LSB] <= smp_ff;
                    rdata_ff[FMT_MSB:FMT_LSB] <= fmt_ff;
                end else if (reg_addr == REG_LOFS_OFS) begin
                    rdata_ff[15:0] <= lofs_ff;
                end else if (reg_addr == REG_GEOM_OFS) begin
                    rdata_ff <= {mcu_rows_ff, mcu_cols_ff};
                end else if (reg_addr == REG_CTRL_OFS) begin
                    rdata_ff[STAT_BUSY_BIT] <= busy_ff;
                    rdata_ff[CTRL_ERR_BIT] <= err_ff;
                end else if (reg_addr == REG_PIXCNT_OFS) begin
                    rdata_ff <= pix_cnt_ff;
                end
            end
        end
    end

    // ==========================================================
    // mcu geometry of the running job
    // ==========================================================
    // size and block layout follow the subsample code latched at start
    always_comb begin
        mcu_bytes = MCU_BYTES_444;
        mcu_w_m1 = 4'h7;
        mcu_h_m1 = 4'h7;
        if (smp_run_ff == SMP_422) begin
            mcu_bytes = MCU_BYTES_422;
            mcu_w_m1 = 4'hF;
        end else if (smp_run_ff == SMP_420) begin
            mcu_bytes = MCU_BYTES_420;
            mcu_w_m1 = 4'hF;
            mcu_h_m1 = 4'hF;
        end
    end

    // byte addresses of the luma and shared chroma samples of a pixel
    always_comb begin
        y_addr = {2'b00, pix_r_ff[2:0], pix_c_ff[2:0]};
        cb_addr = BLK_BYTES + {2'b00, pix_r_ff[2:0], pix_c_ff[2:0]};
        cr_addr = {BLK_BYTES[7:0], 1'b0} + {2'b00, pix_r_ff[2:0], pix_c_ff[2:0]};
        if (smp_run_ff == SMP_422) begin
            // two luma blocks side by side, chroma halved across
            y_addr = {2'b00, pix_c_ff[3], pix_r_ff[2:0], pix_c_ff[2:0]};
            cb_addr = {2'b01, 1'b0, pix_r_ff[2:0], pix_c_ff[3:1]};
            cr_addr = {2'b01, 1'b1, pix_r_ff[2:0], pix_c_ff[3:1]};
        end else if (smp_run_ff == SMP_420) begin
            // four luma blocks in two rows, chroma halved both ways
            y_addr = {1'b0, pix_r_ff[3], pix_c_ff[3], pix_r_ff[2:0], pix_c_ff[2:0]};
            cb_addr = {3'b100, pix_r_ff[3:1], pix_c_ff[3:1]};
            cr_addr = {3'b101, pix_r_ff[3:1], pix_c_ff[3:1]};
        end
    end

    // ==========================================================
    // sequencer
    // ==========================================================
    assign byte_take = ce && in_valid && in_ready_ff;
    assign last_byte = byte_cnt_ff == (mcu_bytes - 9'h001);
    assign last_pix = (pix_c_ff == mcu_w_m1) && (pix_r_ff == mcu_h_m1);
    assign last_col = mcu_col_ff == (mcu_cols_ff - 16'h0001);
    assign last_mcu = last_col && (mcu_row_ff == (mcu_rows_ff - 16'h0001));
    // a dropped pixel needs no fifo room, so padding never stalls
    assign pix_step = (state_ff == ST_EMIT) && (skip_pix || fill_if.ready);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_req && cfg_ok && |mcu_cols_ff && |mcu_rows_ff) begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (byte_take && last_byte) begin
                    nxt_state = ST_EMIT;
                end
            end
            ST_EMIT: begin
                if (pix_step && last_pix) begin
                    nxt_state = last_mcu ? ST_IDLE : ST_LOAD;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // state with its registered decodes for the ports
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            in_ready_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (ce) begin
            state_ff <= nxt_state;
            in_ready_ff <= nxt_state == ST_LOAD;
            busy_ff <= nxt_state != ST_IDLE;
        end
    end

    // subsample code is held for the whole job against mid-run writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            smp_run_ff <= SMP_RST;
        end else if (ce && state_ff == ST_IDLE && nxt_state == ST_LOAD) begin
            smp_run_ff <= smp_ff;
        end
    end

    // ==========================================================
    // mcu capture: blocks arrive y first, then cb, then cr
    // ==========================================================
    always_ff @(posedge clk) begin
        if (byte_take) begin
            mcu_mem[byte_cnt_ff] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            byte_cnt_ff <= 9'h000;
        end else if (byte_take) begin
            byte_cnt_ff <= last_byte ? 9'h000 : byte_cnt_ff + 9'h001;
        end
    end

    // ==========================================================
    // pixel walk inside the mcu and mcu position in the image
    // ==========================================================
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_r_ff <= 4'h0;
            pix_c_ff <= 4'h0;
        end else if (ce && pix_step) begin
            if (pix_c_ff == mcu_w_m1) begin
                pix_c_ff <= 4'h0;
                pix_r_ff <= last_pix ? 4'h0 : pix_r_ff + 4'h1;
            end else begin
                pix_c_ff <= pix_c_ff + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mcu_col_ff <= 16'h0000;
            mcu_row_ff <= 16'h0000;
        end else if (ce) begin
            if (start_req) begin
                mcu_col_ff <= 16'h0000;
                mcu_row_ff <= 16'h0000;
            end else if (pix_step && last_pix) begin
                mcu_col_ff <= last_col ? 16'h0000 : mcu_col_ff + 16'h0001;
                if (last_col) begin
                    mcu_row_ff <= mcu_row_ff + 16'h0001;
                end
            end
        end
    end

    // image coordinates; mcu width is 8 or 16, height 8 or 16
    assign img_x = (mcu_w_m1 == 4'hF) ? {mcu_col_ff, pix_c_ff} : {1'b0, mcu_col_ff, pix_c_ff[2:0]};
    assign img_y = (mcu_h_m1 == 4'hF) ? {mcu_row_ff, pix_r_ff} : {1'b0, mcu_row_ff, pix_r_ff[2:0]};
    // software sizes the offset so that this is the true image width
    assign true_w = ((mcu_w_m1 == 4'hF) ? {mcu_cols_ff, 4'h0} : {1'b0, mcu_cols_ff, 3'h0})
        - {4'h0, lofs_ff};
    assign skip_pix = img_x >= true_w;

    // ==========================================================
    // conversion and pixel push
    // ==========================================================
    mcuyc_csc u_csc (
        .y(mcu_mem[y_addr]),
        .cb(mcu_mem[cb_addr]),
        .cr(mcu_mem[cr_addr]),
        .rgb(pix_rgb)
    );

    assign fill_if.valid = (state_ff == ST_EMIT) && !skip_pix;
    assign fill_if.data = {pix_rgb, img_x[15:0], img_y[15:0]};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pix_cnt_ff <= 32'h0000_0000;
        end else if (ce) begin
            if (start_req && cfg_ok) begin
                pix_cnt_ff <= 32'h0000_0000;
            end else if (fill_if.valid && fill_if.ready) begin
                pix_cnt_ff <= pix_cnt_ff + 32'h0000_0001;
            end
        end
    end

    mcuyc_fifo #(.W(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .wr(fill_if),
        .rd(drain_if)
    );

    // ==========================================================
    // output register: one word held until taken
    // ==========================================================
    assign drain_if.ready = !out_valid_ff || out_ready;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            out_valid_ff <= 1'b0;
            out_word_ff <= '0;
        end else if (ce && drain_if.ready) begin
            out_valid_ff <= drain_if.valid;
            if (drain_if.valid) begin
                out_word_ff <= drain_if.data;
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign in_ready = in_ready_ff;
    assign busy = busy_ff;
    assign out_valid = out_valid_ff;
    assign out_rgb = out_word_ff[55:32];
    assign out_x = out_word_ff[31:16];
    assign out_y = out_word_ff[15:0];
endmodule

// file: mcuyc_pkg.sv
// constants, register map and types of the mcu ycbcr to rgb foreground layer
package mcuyc_pkg;

    // ==========================================================
    // register bus
    // ==========================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam logic [7:0] REG_PFC_OFS = 8'h00;    // foreground_pixel_format_control
    localparam logic [7:0] REG_LOFS_OFS = 8'h04;   // foreground_line_offset
    localparam logic [7:0] REG_GEOM_OFS = 8'h08;   // mcus per line, mcu lines
    localparam logic [7:0] REG_CTRL_OFS = 8'h0C;   // start, busy, error
    localparam logic [7:0] REG_PIXCNT_OFS = 8'h10; // pixels emitted so far

    // ==========================================================
    // fields and reset values
    // ==========================================================
    localparam int unsigned FMT_LSB = 0;
    localparam int unsigned FMT_MSB = 3;
    localparam int unsigned SMP_LSB = 18;
    localparam int unsigned SMP_MSB = 19;
    localparam int unsigned GEOM_COLS_LSB = 0;
    localparam int unsigned GEOM_ROWS_LSB = 16;
    localparam int unsigned CTRL_START_BIT = 0;
    localparam int unsigned CTRL_ERR_BIT = 1;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam logic [3:0] FMT_RST = 4'h0;
    localparam logic [1:0] SMP_RST = 2'h0;
    localparam logic [15:0] LOFS_RST = 16'h0000;
    localparam logic [15:0] GEOM_RST = 16'h0000;
    localparam logic [3:0] FMT_YCBCR = 4'hB;       // 1011
    localparam logic [1:0] SMP_444 = 2'h0;
    localparam logic [1:0] SMP_422 = 2'h1;
    localparam logic [1:0] SMP_420 = 2'h2;

    // ==========================================================
    // mcu layout
    // ==========================================================
    localparam int unsigned MCU_MAX_BYTES = 384;
    localparam logic [8:0] MCU_BYTES_444 = 9'h0C0; // 192
    localparam logic [8:0] MCU_BYTES_422 = 9'h100; // 256
    localparam logic [8:0] MCU_BYTES_420 = 9'h180; // 384
    localparam logic [8:0] BLK_BYTES = 9'h040;     // one 8x8 block

    // ==========================================================
    // colour conversion, scaled by 256
    // ==========================================================
    localparam logic signed [10:0] COEF_RV = 11'sh167; // 1.402
    localparam logic signed [10:0] COEF_GU = 11'sh058; // 0.344
    localparam logic signed [10:0] COEF_GV = 11'sh0B7; // 0.714
    localparam logic signed [10:0] COEF_BU = 11'sh1C6; // 1.772
    localparam logic [9:0] CHROMA_MID = 10'h080;

    // ==========================================================
    // pixel word and states
    // ==========================================================
    localparam int unsigned PIX_W = 56; // rgb, x, y
    localparam int unsigned FIFO_DEPTH_DEF = 32;
    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_EMIT} mcuyc_state_e;

endpackage

// file: mcuyc_strm_if.sv
// valid and ready stream carrier between the converter and its fifo
`timescale 1ns/1ps
interface mcuyc_strm_if #(parameter int W = 56) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// file: mcuyc_fifo.sv
// synchronous fifo between pixel conversion and the output port
`timescale 1ns/1ps
module mcuyc_fifo #(
    parameter int W = 56,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    mcuyc_strm_if.snk wr,
    mcuyc_strm_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    // ==========================================================
    // parameter check
    // ==========================================================
    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("fifo depth must be a power of two of at least two");
        end
    endgenerate

    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wptr_ff;
    logic [AW:0] rptr_ff;
    logic do_wr;
    logic do_rd;

    // extra pointer bit tells full from empty
    assign wr.ready = (wptr_ff ^ rptr_ff) != {1'b1, {AW{1'b0}}};
    assign rd.valid = wptr_ff != rptr_ff;
    assign rd.data = mem[rptr_ff[AW-1:0]];
    assign do_wr = ce && wr.valid && wr.ready;
    assign do_rd = ce && rd.valid && rd.ready;

    // storage, no reset needed
    always_ff @(posedge clk) begin
        if (do_wr) begin
            mem[wptr_ff[AW-1:0]] <= wr.data;
        end
    end

    // pointers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
        end else begin
            if (do_wr) begin
                wptr_ff <= wptr_ff + 1'b1;
            end
            if (do_rd) begin
                rptr_ff <= rptr_ff + 1'b1;
            end
        end
    end
endmodule

// file: mcuyc_csc.sv
// ycbcr to rgb colour conversion, combinational
`timescale 1ns/1ps
module mcuyc_csc (
    input wire logic [7:0] y,
    input wire logic [7:0] cb,
    input wire logic [7:0] cr,
    output logic [23:0] rgb
);
    import mcuyc_pkg::*;

    logic signed [9:0] cbd;
    logic signed [9:0] crd;
    logic signed [19:0] ysh;
    logic signed [19:0] r_acc;
    logic signed [19:0] g_acc;
    logic signed [19:0] b_acc;

    // saturate a scaled sum to one byte
    function automatic logic [7:0] clamp8(input logic signed [19:0] v);
        logic [7:0] res;
        res = v[15:8];
        if (v < 0) begin
            res = 8'h00;
        end else if (v[19:16] != 4'h0) begin
            res = 8'hFF;
        end
        return res;
    endfunction

    // chroma centred on zero, luma scaled with half-lsb rounding
    assign cbd = signed'({2'b00, cb} - CHROMA_MID);
    assign crd = signed'({2'b00, cr} - CHROMA_MID);
    assign ysh = signed'({4'h0, y, 8'h80});
    assign r_acc = ysh + 20'(crd * COEF_RV);
    assign g_acc = ysh - 20'(cbd * COEF_GU) - 20'(crd * COEF_GV);
    assign b_acc = ysh + 20'(cbd * COEF_BU);
    assign rgb = {clamp8(r_acc), clamp8(g_acc), clamp8(b_acc)};
endmodule

// file: mcuyc_layer_assertions.sv
// port assertions for the mcu to rgb foreground layer
`timescale 1ns/1ps
module mcuyc_layer_assertions
    import mcuyc_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [23:0] out_rgb,
    input wire logic [15:0] out_x,
    input wire logic [15:0] out_y,
    input wire logic busy
);
    default clocking dck @(posedge clk); endclocking
    default disable iff (!rstn);
    // =========
    // bus and streams
    sequence s_start;
        reg_wr && reg_addr == REG_CTRL_OFS && reg_wdata[0];
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data off slot");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h14 |=> reg_rdata == 0)
        else $error("unmapped read");
    a_ctrl_bits: assert property (
        reg_rd && reg_addr == REG_CTRL_OFS |=> !reg_rdata[31:2])
        else $error("ctrl spare bits");
    a_out_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable({out_rgb, out_x, out_y}))
        else $error("pixel not held");
    a_out_drop: assert property ($fell(out_valid) |-> $past(out_ready))
        else $error("pixel lost");
    a_ready_busy: assert property (in_ready |-> busy)
        else $error("input open while idle");
    a_start_opens: assert property (s_start ##1 $rose(busy) |-> in_ready)
        else $error("start without input");
    a_busy_cause: assert property ($rose(busy) |-> $past(reg_wr))
        else $error("busy without start");
endmodule
bind mcuyc_layer mcuyc_layer_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_ready(in_ready), .out_valid(out_valid),
    .out_ready(out_ready), .out_rgb(out_rgb), .out_x(out_x), .out_y(out_y), .busy(busy));

// file: mcuyc_dec_model.sv
// decoder output buffer model serving one mcu per go
`timescale 1ns/1ps
module mcuyc_dec_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic go,
    input wire logic slow,
    input wire logic [8:0] total,
    input wire logic [7:0] chroma,
    input wire logic in_ready,
    output logic in_valid,
    output logic [7:0] in_data
);
    logic [8:0] idx;
    // y bytes, then cb and cr; idle line inverted
    assign in_data = !in_valid ? ~idx[7:0] : idx < total - 9'h080 ? idx[7:0] : chroma;
    // slow drops valid after each take; reset and go act at the edge
    always_ff @(posedge clk) begin
        if (!rstn || !go) begin
            idx <= 9'h000;
            in_valid <= 1'b0;
        end else if (in_valid && in_ready) begin
            idx <= idx + 9'h001;
            in_valid <= !slow && idx + 9'h001 < total;
        end else begin
            in_valid <= idx < total;
        end
    end
endmodule

// file: mcuyc_layer_tb_top.sv
// self-checking bench for the mcu to rgb foreground layer
`timescale 1ns/1ps
module mcuyc_layer_tb_top;
    import mcuyc_pkg::*;
    logic clk, rstn, ce, reg_wr, reg_rd, in_valid, in_ready, out_valid, out_ready, busy, go, slow;
    logic [7:0] reg_addr, in_data, chroma;
    logic [31:0] reg_wdata, reg_rdata;
    logic [23:0] out_rgb;
    logic [15:0] out_x, out_y;
    logic [8:0] total;
    int error_cnt, checks;
    mcuyc_layer #(.FIFO_DEPTH(32)) uut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_ready(out_ready), .out_rgb(out_rgb), .out_x(out_x), .out_y(out_y), .busy(busy));
    mcuyc_dec_model dec (.clk(clk), .rstn(rstn), .go(go), .slow(slow), .total(total),
        .chroma(chroma), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // =========
    // report and compare
    task automatic test_done;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic note(input bit bad, input string m);
        checks++;
        if (bad) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
        note(g !== e, "register");
    endtask
    task automatic chk_pix(input logic [55:0] g, input logic [55:0] e);
        note(g !== e, "pixel");
    endtask
    // bounded wait, values seen as sampled at the edge
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v) begin
            @(posedge clk);
            n++;
            if (n > 4000) begin
                note(1'b1, "timeout");
                test_done();
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    function automatic logic [7:0] clp(input int v);
        return v < 0 ? 8'h00 : v > 255 ? 8'hFF : 8'(v);
    endfunction
    // luma index: blocks in raster, then raster inside each 8x8
    function automatic logic [55:0] exp_pix(input int w, input int r, input int c, input int k);
        int y;
        y = ((r / 8) * (w / 8) + c / 8) * 64 + r % 8 * 8 + c % 8;
        return {clp(y + 22 * k), clp(y - 17 * k), clp(y + 28 * k), 16'(c), 16'(r)};
    endfunction
    // =========
    // scenarios
    task automatic t_regs;
        logic [31:0] d;
        for (int a = 0; a < 24; a += 4) begin
            rd(8'(a), d);
            chk_reg(d, 32'h0000_0000);
        end
        wr(REG_PFC_OFS, 32'h0008_000B);
        rd(REG_PFC_OFS, d);
        chk_reg(d, 32'h0008_000B);
    endtask
    task automatic t_bad;
        logic [31:0] d;
        wr(REG_GEOM_OFS, 32'h0001_0001);
        for (int i = 0; i < 2; i++) begin
            wr(REG_PFC_OFS, i ? 32'h000C_000B : 32'h0000_0003);
            wr(REG_CTRL_OFS, 32'h0000_0001);
            rd(REG_CTRL_OFS, d);
            chk_reg(d, 32'h0000_0002);
            wr(REG_CTRL_OFS, 32'h0000_0002);
            rd(REG_CTRL_OFS, d);
            chk_reg(d, 32'h0000_0000);
        end
    endtask
    // one mcu frame; stall holds the sink for 700 cycles, past the point where the fifo refuses
    task automatic t_frame(input logic [1:0] smp, input int lofs, input int k, input bit stall);
        int w, h;
        logic [31:0] d;
        w = smp == SMP_444 ? 8 : 16;
        h = smp == SMP_420 ? 16 : 8;
        go <= 1'b0;
        slow <= stall;
        chroma <= k ? 8'h90 : 8'h80;
        total <= smp == SMP_444 ? MCU_BYTES_444 : smp == SMP_422 ? MCU_BYTES_422 : MCU_BYTES_420;
        out_ready <= !stall;
        wr(REG_PFC_OFS, {12'h000, smp, 14'h0000, FMT_YCBCR});
        wr(REG_LOFS_OFS, 32'(lofs));
        wr(REG_CTRL_OFS, 32'h0000_0001);
        go <= 1'b1;
        if (stall) begin
            repeat (700) @(posedge clk);
            chk_reg({31'h0, busy}, 32'h0000_0001);
            out_ready <= 1'b1;
            @(posedge clk);
        end
        for (int r = 0; r < h; r++) begin
            for (int c = 0; c < w - lofs; c++) begin
                wait_lvl(out_valid, 1'b1);
                chk_pix({out_rgb, out_x, out_y}, exp_pix(w, r, c, k));
                @(posedge clk);
            end
        end
        wait_lvl(busy, 1'b0);
        rd(REG_PIXCNT_OFS, d);
        chk_reg(d, 32'(h * (w - lofs)));
    endtask
    initial begin
        {rstn, reg_wr, reg_rd, go, slow, out_ready, reg_addr, reg_wdata} = '0;
        {total, chroma, error_cnt, checks} = '0;
        ce = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_bad();
        t_frame(SMP_444, 3, 0, 1'b1);
        t_frame(SMP_422, 0, 1, 1'b0);
        t_frame(SMP_420, 5, 0, 1'b0);
        test_done();
    end
endmodule
